// ---- verilog/pms_pkg.sv ----
// Constants, register map and state codes of the power mode sequencer.
// Assumes a single 40 MHz reference clock; the slow oscillator is an enable.
`default_nettype none

package pms_pkg;

  // Clock and slow-oscillator rate
  localparam int CLK_HZ = 40_000_000;
  localparam int SLOW_CLK_HZ = 31_250;
  localparam int SLOW_DIV = CLK_HZ / SLOW_CLK_HZ;
  localparam int SLOW_DIV_W = 11;
  localparam logic [SLOW_DIV_W-1:0] SLOW_DIV_LAST = SLOW_DIV_W'(SLOW_DIV - 1);

  // Register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_GEN_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_WAKE_LOW = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_WAKE_HIGH = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DORMANT_CFG = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_RESUME1_CFG = 8'h10;

  // General control fields
  localparam int GC_POR_LEVELS = 7;
  localparam int GC_REAPPLY = 6;
  localparam int GC_WIDE_TIMER = 5;
  localparam int GC_TIMER_WAKE = 4;
  localparam int GC_PIN_POL = 3;
  localparam int GC_PIN_WAKE = 2;
  localparam int GC_SLEEP_GO = 1;
  localparam int GC_CLK_SEL = 0;
  localparam logic [7:0] GC_RESET = 8'h08;
  localparam logic [7:0] GC_STORE_MASK = 8'hbd;

  // State configuration fields
  localparam int CFG_DWELL_LSB = 16;
  localparam int CFG_DWELL_MSB = 20;
  localparam int CFG_CLK_GATE = 14;
  localparam int CFG_ANA_PFM = 9;
  localparam int CFG_CORE_PFM = 8;
  localparam int CFG_IO_EN = 5;
  localparam int CFG_PLL_EN = 4;
  localparam int CFG_ANA_EN = 1;
  localparam int CFG_CORE_EN = 0;
  localparam logic [DATA_W-1:0] CFG_RW_MASK = 32'h001f_4331;
  localparam logic [DATA_W-1:0] DORMANT_CFG_RESET = 32'h0010_0000;
  localparam logic [DATA_W-1:0] RESUME1_CFG_RESET = 32'h0010_0020;
  // Fixed configurations of the states without a register here
  localparam logic [DATA_W-1:0] RESUME2_CFG = 32'h0010_0033;
  localparam logic [DATA_W-1:0] RUN_CFG = 32'h0000_0033;
  localparam logic [DATA_W-1:0] SLEEP1_CFG = 32'h0010_0022;
  localparam logic [DATA_W-1:0] SLEEP2_CFG = 32'h0010_0022;

  localparam int DWELL_W = 32;

  typedef enum logic [2:0] {
    ST_DORMANT = 3'b000,
    ST_RESUME1 = 3'b001,
    ST_RESUME2 = 3'b010,
    ST_RUN = 3'b011,
    ST_SLEEP1 = 3'b100,
    ST_SLEEP2 = 3'b101
  } pms_state_e;

endpackage

`default_nettype wire

// ---- verilog/pms_dwell_timer.sv ----
// Minimum dwell timer: counts 2**log2 enabled ticks from a start strobe.
// Assumes the start strobe coincides with the state change it times.
`timescale 1ns/1ps
`default_nettype none

module pms_dwell_timer
  import pms_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic i_tick,
  input wire logic [4:0] i_log2,
  output logic o_expired
);

  logic [DWELL_W-1:0] cnt_ff;
  logic [DWELL_W-1:0] target;

  // Field 31 needs the full 32-bit count
  assign target = 32'h1 << i_log2;
  // A field lowered mid-state must not push expiry out past the counter wrap
  assign o_expired = (cnt_ff >= target);

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cnt_ff <= '0;
    else if (i_start)
      cnt_ff <= '0;
    else if (i_tick && !o_expired)
      cnt_ff <= cnt_ff + 32'h1;
  end

endmodule // pms_dwell_timer

`default_nettype wire

// ---- verilog/pms_sequencer.sv ----
// Power mode sequencer: registers, state walk and supply controls.
// Assumes register strobes, resume pin, supply-good and counter inputs are synchronous.
`timescale 1ns/1ps
`default_nettype none

module pms_sequencer
  import pms_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [ADDR_W-1:0] i_reg_addr,
  input wire logic [DATA_W-1:0] i_reg_wdata,
  input wire logic i_resume_pin,
  input wire logic [63:0] i_rtc_count,
  input wire logic i_core_good,
  input wire logic i_analog_good,
  input wire logic i_pll_good,
  input wire logic i_io_good,
  output logic [DATA_W-1:0] o_reg_rdata,
  output logic o_reg_rvalid,
  output logic o_core_buck_en,
  output logic o_analog_buck_en,
  output logic o_pll_reg_en,
  output logic o_io_supply_en,
  output logic o_core_buck_pfm,
  output logic o_analog_buck_pfm,
  output logic o_tile_clk_gate,
  output logic o_por_levels,
  output logic [2:0] o_state
);

  pms_state_e state_ff;
  pms_state_e nxt_state;
  logic [7:0] ctrl_ff;
  logic reapply_ff;
  logic [DATA_W-1:0] wake_low_ff;
  logic [DATA_W-1:0] wake_high_ff;
  logic [DATA_W-1:0] dormant_cfg_ff;
  logic [DATA_W-1:0] resume1_cfg_ff;
  logic [SLOW_DIV_W-1:0] div_ff;
  logic slow_tick;
  logic tick;
  logic dwell_done;
  logic [DATA_W-1:0] cur_cfg;
  logic timer_hit;
  logic pin_hit;
  logic wake;
  logic supplies_good;
  logic wr_ctrl;
  logic sleep_taken;
  logic run_last_ff;

  assign wr_ctrl = i_reg_wr && (i_reg_addr == OFS_GEN_CTRL);
  assign sleep_taken = (state_ff == ST_RUN) && ctrl_ff[GC_SLEEP_GO];

  // Slow oscillator stands in as a one-cycle enable
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      div_ff <= '0;
    else if (div_ff == SLOW_DIV_LAST)
      div_ff <= '0;
    else
      div_ff <= div_ff + 11'h1;
  end

  assign slow_tick = (div_ff == SLOW_DIV_LAST);
  // Clock select only matters while dormant; elsewhere the default clock runs
  assign tick = (state_ff == ST_DORMANT && !ctrl_ff[GC_CLK_SEL]) ? slow_tick : 1'b1;

  // General control
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ctrl_ff <= GC_RESET;
    else
    begin
      if (wr_ctrl)
        ctrl_ff <= (i_reg_wdata[7:0] & GC_STORE_MASK) | {6'h0, i_reg_wdata[GC_SLEEP_GO] | ctrl_ff[GC_SLEEP_GO], 1'b0}
                   | {7'h0, i_reg_wdata[GC_CLK_SEL]};
      // A fresh write of the sleep bit wins over the self clear
      if (sleep_taken && !(wr_ctrl && i_reg_wdata[GC_SLEEP_GO]))
        ctrl_ff[GC_SLEEP_GO] <= 1'b0;
    end
  end

  // Write-only strobe, never stored
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      reapply_ff <= 1'b0;
    else
      reapply_ff <= wr_ctrl && i_reg_wdata[GC_REAPPLY];
  end

  // Wake time and state configurations
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wake_low_ff <= '0;
      wake_high_ff <= '0;
      dormant_cfg_ff <= DORMANT_CFG_RESET;
      resume1_cfg_ff <= RESUME1_CFG_RESET;
    end
    else if (i_reg_wr)
    begin
      if (i_reg_addr == OFS_WAKE_LOW)
        wake_low_ff <= i_reg_wdata;
      if (i_reg_addr == OFS_WAKE_HIGH)
        wake_high_ff <= i_reg_wdata;
      // Read-only analog enable keeps its reset value
      if (i_reg_addr == OFS_DORMANT_CFG)
        dormant_cfg_ff <= (i_reg_wdata & CFG_RW_MASK) | (DORMANT_CFG_RESET & ~CFG_RW_MASK);
      if (i_reg_addr == OFS_RESUME1_CFG)
        resume1_cfg_ff <= (i_reg_wdata & CFG_RW_MASK) | (RESUME1_CFG_RESET & ~CFG_RW_MASK);
    end
  end

  // Registered read port, unmapped addresses read zero
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_reg_rdata <= '0;
      o_reg_rvalid <= 1'b0;
    end
    else
    begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd)
      begin
        unique case (i_reg_addr)
          OFS_GEN_CTRL: o_reg_rdata <= {24'h0, ctrl_ff};
          OFS_WAKE_LOW: o_reg_rdata <= wake_low_ff;
          OFS_WAKE_HIGH: o_reg_rdata <= wake_high_ff;
          OFS_DORMANT_CFG: o_reg_rdata <= dormant_cfg_ff;
          OFS_RESUME1_CFG: o_reg_rdata <= resume1_cfg_ff;
          default: o_reg_rdata <= '0;
        endcase
      end
    end
  end

  // Wake conditions
  always_comb
  begin
    if (ctrl_ff[GC_WIDE_TIMER])
      timer_hit = {i_rtc_count[63:32], i_rtc_count[31:0]} >= {wake_high_ff, wake_low_ff};
    else
      timer_hit = i_rtc_count[31:0] >= wake_low_ff;
  end

  assign pin_hit = ctrl_ff[GC_PIN_WAKE] && (i_resume_pin == ctrl_ff[GC_PIN_POL]);
  assign wake = pin_hit || (ctrl_ff[GC_TIMER_WAKE] && timer_hit);

  always_comb
  begin
    unique case (state_ff)
      ST_DORMANT: cur_cfg = dormant_cfg_ff;
      ST_RESUME1: cur_cfg = resume1_cfg_ff;
      ST_RESUME2: cur_cfg = RESUME2_CFG;
      ST_RUN: cur_cfg = RUN_CFG;
      ST_SLEEP1: cur_cfg = SLEEP1_CFG;
      ST_SLEEP2: cur_cfg = SLEEP2_CFG;
      default: cur_cfg = RUN_CFG;
    endcase
  end

  // Only supplies enabled in this state have to report good
  assign supplies_good = (!cur_cfg[CFG_CORE_EN] || i_core_good) && (!cur_cfg[CFG_ANA_EN] || i_analog_good)
                         && (!cur_cfg[CFG_PLL_EN] || i_pll_good) && (!cur_cfg[CFG_IO_EN] || i_io_good);

  pms_dwell_timer u_dwell (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_start(nxt_state != state_ff),
    .i_tick(tick),
    .i_log2(cur_cfg[CFG_DWELL_MSB:CFG_DWELL_LSB]),
    .o_expired(dwell_done)
  );

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_DORMANT:
        if (dwell_done && wake)
          nxt_state = ST_RESUME1;
      ST_RESUME1:
        if (dwell_done && supplies_good)
          nxt_state = ST_RESUME2;
      ST_RESUME2:
        if (dwell_done && supplies_good)
          nxt_state = ST_RUN;
      ST_RUN:
        if (ctrl_ff[GC_SLEEP_GO])
          nxt_state = ST_SLEEP1;
      ST_SLEEP1:
        if (dwell_done)
          nxt_state = ST_SLEEP2;
      ST_SLEEP2:
        if (dwell_done)
          nxt_state = ST_DORMANT;
      default:
        nxt_state = ST_RUN;
    endcase
  end

  // Power comes up run_state
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state_ff <= ST_RUN;
    else
      state_ff <= nxt_state;
  end

  // Run entry is detected against last cycle's state
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      run_last_ff <= 1'b1;
    else
      run_last_ff <= (state_ff == ST_RUN);
  end

  // Supply controls; run-state settings load on entry or on re-apply only
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_core_buck_en <= RUN_CFG[CFG_CORE_EN];
      o_analog_buck_en <= RUN_CFG[CFG_ANA_EN];
      o_pll_reg_en <= RUN_CFG[CFG_PLL_EN];
      o_io_supply_en <= RUN_CFG[CFG_IO_EN];
      o_core_buck_pfm <= RUN_CFG[CFG_CORE_PFM];
      o_analog_buck_pfm <= RUN_CFG[CFG_ANA_PFM];
      o_tile_clk_gate <= RUN_CFG[CFG_CLK_GATE];
    end
    else if (state_ff != ST_RUN || !run_last_ff || reapply_ff)
    begin
      o_core_buck_en <= cur_cfg[CFG_CORE_EN];
      o_analog_buck_en <= cur_cfg[CFG_ANA_EN];
      o_pll_reg_en <= cur_cfg[CFG_PLL_EN];
      o_io_supply_en <= cur_cfg[CFG_IO_EN];
      o_core_buck_pfm <= cur_cfg[CFG_CORE_PFM];
      o_analog_buck_pfm <= cur_cfg[CFG_ANA_PFM];
      o_tile_clk_gate <= cur_cfg[CFG_CLK_GATE];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_por_levels <= 1'b0;
      o_state <= ST_RUN;
    end
    else
    begin
      o_por_levels <= ctrl_ff[GC_POR_LEVELS] && (state_ff == ST_RESUME1 || state_ff == ST_RESUME2);
      o_state <= state_ff;
    end
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  AST_SLEEP_START: assert property ((state_ff == ST_RUN && ctrl_ff[GC_SLEEP_GO] && !wr_ctrl)
    |=> state_ff == ST_SLEEP1 && !ctrl_ff[GC_SLEEP_GO])
    else $error("sleep request not taken or not cleared");
  AST_DORMANT_DWELL: assert property ((state_ff == ST_DORMANT && !dwell_done) |=> state_ff == ST_DORMANT)
    else $error("dormant left before dwell expired");
  AST_NO_WAKE_HOLD: assert property ((state_ff == ST_DORMANT && !ctrl_ff[GC_PIN_WAKE] && !ctrl_ff[GC_TIMER_WAKE])
    |=> state_ff == ST_DORMANT)
    else $error("dormant left without wake source");
  AST_PIN_WAKE: assert property ((state_ff == ST_DORMANT && dwell_done && ctrl_ff[GC_PIN_WAKE]
    && i_resume_pin == ctrl_ff[GC_PIN_POL]) |=> state_ff == ST_RESUME1)
    else $error("resume pin did not wake");
  AST_RESUME_WAIT_GOOD: assert property ((state_ff == ST_RESUME1 && !supplies_good) |=> state_ff == ST_RESUME1)
    else $error("resume phase left with supply not good");
  AST_HIGH_IGNORED: assert property ((!ctrl_ff[GC_WIDE_TIMER]) |-> timer_hit == (i_rtc_count[31:0] >= wake_low_ff))
    else $error("high wake word used in 32-bit mode");
  AST_REAPPLY_PULSE: assert property ((reapply_ff && !(wr_ctrl && i_reg_wdata[GC_REAPPLY]))
    |=> !reapply_ff ##0 o_reg_rdata[GC_REAPPLY] == 1'b0 || !o_reg_rvalid)
    else $error("re-apply strobe did not self clear");
  AST_SLOW_SPACING: assert property ((state_ff == ST_DORMANT && !ctrl_ff[GC_CLK_SEL] && tick)
    |=> (!tick || state_ff != ST_DORMANT || ctrl_ff[GC_CLK_SEL]) [*8])
    else $error("slow dwell tick too frequent");
  AST_CLK_GATE: assert property ((state_ff == ST_DORMANT && $past(state_ff) == ST_DORMANT)
    |=> o_tile_clk_gate == $past(dormant_cfg_ff[CFG_CLK_GATE]))
    else $error("clock gate does not follow dormant setting");
  AST_CORE_PFM: assert property ((state_ff == ST_RESUME1) |=> o_core_buck_pfm == $past(resume1_cfg_ff[CFG_CORE_PFM]))
    else $error("core modulation does not follow resume setting");
  AST_POR_LEVELS: assert property ((state_ff == ST_DORMANT) |=> !o_por_levels)
    else $error("power-on levels selected outside waking");

  COV_PIN_WAKE: cover property (state_ff == ST_DORMANT && pin_hit ##1 state_ff == ST_RESUME1);
  COV_TIMER_WAKE: cover property (state_ff == ST_DORMANT && !pin_hit ##1 state_ff == ST_RESUME1);
  COV_SLEEP: cover property (state_ff == ST_SLEEP2 ##1 state_ff == ST_DORMANT);
  COV_REAPPLY: cover property (state_ff == ST_RUN && reapply_ff);

endmodule // pms_sequencer

`default_nettype wire

// ---- dv/pms_supply_model.sv ----
// Behavioural model of the on-chip supplies: each reports good a while after enable.
// Assumes enables come from the sequencer's registered outputs on the same clock.
`timescale 1ns/1ps
`default_nettype none

module pms_supply_model #(
  parameter int DELAY = 40
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_en,
  output logic [3:0] o_good
);
  logic [7:0] cnt_ff [4];

  // Good drops at once on disable; a real regulator gives no grace either
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (!i_rst_n)
        cnt_ff[i] <= 8'h00;
      else if (!i_en[i])
        cnt_ff[i] <= 8'h00;
      else if (cnt_ff[i] != 8'(DELAY))
        cnt_ff[i] <= cnt_ff[i] + 8'h01;
    end
  end

  always_comb
  begin
    for (int i = 0; i < 4; i++)
      o_good[i] = i_en[i] && (cnt_ff[i] == 8'(DELAY));
  end
endmodule // pms_supply_model

`default_nettype wire

// ---- dv/power_mode_sequencer_tb.sv ----
// Self-checking bench of the power mode sequencer with a supply model.
// Assumes the sequencer's fixed state configurations; one full sleep loop is run.
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end

module power_mode_sequencer_tb;
  import pms_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 32'h0000_0000;
  logic resume_pin = 1'b1;
  logic [63:0] rtc = 64'h0000_0000_0000_0000;
  logic [3:0] good;
  logic [DATA_W-1:0] rdata;
  logic rvalid;
  logic core_en, ana_en, pll_en, io_en, core_pfm, ana_pfm, clk_gate, por;
  logic [2:0] state;
  logic [DATA_W-1:0] rd_val;
  logic [15:0] seed = 16'd32845;
  logic [31:0] rnd;
  int error_cnt = 0;
  int total_checks = 0;

  always #12.5 i_ref_clk = ~i_ref_clk;

  pms_sequencer dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_resume_pin(resume_pin), .i_rtc_count(rtc),
    .i_core_good(good[0]), .i_analog_good(good[1]), .i_pll_good(good[2]), .i_io_good(good[3]),
    .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_core_buck_en(core_en), .o_analog_buck_en(ana_en),
    .o_pll_reg_en(pll_en), .o_io_supply_en(io_en), .o_core_buck_pfm(core_pfm),
    .o_analog_buck_pfm(ana_pfm), .o_tile_clk_gate(clk_gate), .o_por_levels(por), .o_state(state));

  pms_supply_model #(.DELAY(40)) supplies (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_en({io_en, pll_en, ana_en, core_en}), .o_good(good));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Expected {io, pll, analog, core, analog pfm, core pfm, gate} of a configuration
  function automatic logic [6:0] exp_out(input logic [31:0] c);
    return {c[CFG_IO_EN], c[CFG_PLL_EN], c[CFG_ANA_EN], c[CFG_CORE_EN], c[CFG_ANA_PFM], c[CFG_CORE_PFM],
      c[CFG_CLK_GATE]};
  endfunction

  task automatic summarize();
    if (error_cnt == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic next_rnd();
    seed = lfsr(seed);
    rnd[15:0] = seed;
    seed = lfsr(seed);
    rnd[31:16] = seed;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge i_ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge i_ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge i_ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(rvalid, 1'b1)
    rd_val = rdata;
  endtask

  task automatic wait_state(input logic [2:0] st, input int bound);
    int n;
    n = 0;
    while (state !== st)
    begin
      @(posedge i_ref_clk);
      #1;
      n++;
      if (n > bound)
      begin
        error_cnt++;
        $display("[ERR] %0t state wait timed out", $time);
        summarize();
      end
    end
  endtask

  task automatic stay_state(input logic [2:0] st, input int cycles);
    repeat (cycles)
    begin
      @(posedge i_ref_clk);
      #1;
      `CHK(state, st)
    end
  endtask

  initial
  begin
    repeat (12) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    rd(OFS_GEN_CTRL);
    `CHK(rd_val, 32'h0000_0008)
    rd(OFS_WAKE_LOW);
    `CHK(rd_val, 32'h0000_0000)
    rd(OFS_WAKE_HIGH);
    `CHK(rd_val, 32'h0000_0000)
    rd(OFS_DORMANT_CFG);
    `CHK(rd_val, 32'h0010_0000)
    rd(OFS_RESUME1_CFG);
    `CHK(rd_val, 32'h0010_0020)
    rd(8'h14);
    `CHK(rd_val, 32'h0000_0000)
    // Random readback; reserved and read-only bits must stay at reset value
    for (int i = 0; i < 4; i++)
    begin
      next_rnd();
      wr(OFS_DORMANT_CFG, rnd);
      rd(OFS_DORMANT_CFG);
      `CHK(rd_val, rnd & CFG_RW_MASK)
      wr(OFS_WAKE_HIGH, rnd);
      rd(OFS_WAKE_HIGH);
      `CHK(rd_val, rnd)
    end
    wr(OFS_WAKE_LOW, 32'h0000_0100);
    wr(OFS_WAKE_HIGH, 32'h0000_0001);
    rtc <= 64'h0000_0000_0000_0200;
    wr(OFS_DORMANT_CFG, 32'h0002_4320);
    wr(OFS_RESUME1_CFG, 32'h0003_0031);
    wr(OFS_GEN_CTRL, 32'h0000_00f5);
    rd(OFS_GEN_CTRL);
    `CHK(rd_val, 32'h0000_00b5)
    // Sleep with the slow oscillator selected, so the dormant dwell runs on the slow tick
    wr(OFS_GEN_CTRL, 32'h0000_00b6);
    wait_state(ST_SLEEP1, 5);
    `CHK({core_en, pll_en}, 2'b00)
    rd(OFS_GEN_CTRL);
    `CHK(rd_val, 32'h0000_00b4)
    wait_state(ST_SLEEP2, 70000);
    wait_state(ST_DORMANT, 70000);
    repeat (2) @(posedge i_ref_clk);
    #1;
    `CHK({io_en, pll_en, ana_en, core_en, ana_pfm, core_pfm, clk_gate}, exp_out(32'h0002_4320))
    // Low word reached but high word not: must stay with 64-bit compare
    stay_state(ST_DORMANT, 60);
    @(posedge i_ref_clk);
    resume_pin <= 1'b0;
    // Four slow ticks take at least 3841 cycles; the default clock would leave at once
    stay_state(ST_DORMANT, 2000);
    wait_state(ST_RESUME1, 4000);
    stay_state(ST_RESUME1, 20);
    `CHK({io_en, pll_en, ana_en, core_en}, 4'b1101)
    `CHK(por, 1'b1)
    wait_state(ST_RESUME2, 60);
    wait_state(ST_RUN, 70000);
    repeat (2) @(posedge i_ref_clk);
    #1;
    `CHK({io_en, pll_en, ana_en, core_en, ana_pfm, core_pfm, clk_gate}, exp_out(RUN_CFG))
    `CHK(por, 1'b0)
    summarize();
  end
endmodule // power_mode_sequencer_tb

`default_nettype wire
